// >>> crc_ctrl_pkg.sv
// Constants and carrier types shared by the CRC engine, its checker and its testbench.
// Assumes a single 250 MHz clock and a plain strobe register port.
// How it works
// - Clearing the unit enable resets the engine, FIFO pointers, data and result, not the controls.
// - With idle stop set, the engine freezes while the chip is idle; otherwise it keeps running.
// - A five-bit count shows FIFO words; depth is 16 for poly length field <= 7, else 8.
// - With interrupt select 1, the CRC event fires when the FIFO runs empty by a pop.
// - With interrupt select 0, the CRC event fires once shifting ends and the result is valid.
// - Writing shift go 1 starts the shifter on FIFO words and writing 0 turns it off.
// - A data word is the data width field plus one bits wide.
// - Unimplemented control bits read as zero and ignore writes.
// - The polynomial is the poly length field plus one bits long.
package crc_ctrl_pkg;

  // Register indices on the plain port
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] OFF_CTRL1 = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL2 = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_DATA = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_POLY = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 3'h5;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h6;

  // Widths
  localparam int DATA_W = 32;
  localparam int CTRL_W = 16;
  localparam int FIELD_W = 5;
  localparam int CNT_W = 5;

  // Primary control field positions
  localparam int BIT_UNIT_EN = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int CNT_LSB = 8;
  localparam int BIT_FULL = 7;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_ISEL = 5;
  localparam int BIT_GO = 4;
  localparam int BIT_LSB_FIRST = 3;

  // Width control field positions
  localparam int DW_LSB = 8;
  localparam int PL_LSB = 0;

  // Writable bits and reset values
  localparam logic [CTRL_W-1:0] CTRL1_WMASK = 16'ha038;
  localparam logic [CTRL_W-1:0] CTRL1_RESET = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL2_WMASK = 16'h1f1f;
  localparam logic [CTRL_W-1:0] CTRL2_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] POLY_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] SEED_RESET = 32'h00000000;

  // FIFO depth selection
  localparam logic [FIELD_W-1:0] PLEN_SHORT_MAX = 5'h07;
  localparam logic [CNT_W-1:0] DEPTH_SHORT_POLY = 5'h10;
  localparam logic [CNT_W-1:0] DEPTH_LONG_POLY = 5'h08;

  // Interrupt status layout
  localparam int IRQ_W = 2;
  localparam int IRQ_CRC = 0;
  localparam int IRQ_DROP = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_s;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_SHIFT = 3'b100
  } eng_state_e;

endpackage

// >>> crc_word_mem.sv
// Word store behind the CRC input FIFO.
// Assumes the caller keeps pointers and never reads an unwritten slot.
`timescale 1ns/1ns
`default_nettype none
module crc_word_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock
  input wire logic clock_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // Read port, data one cycle after the enable
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;

  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("crc_word_mem: DEPTH does not fit AW");
    end
  end

  // Storage has no reset; contents are only read after a write
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_data_reg <= mem_reg[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule
`default_nettype wire

// >>> crc_engine.sv
// Programmable CRC engine: control registers, input FIFO and bit shifter.
// Assumes one clock domain, a synchronous reset and a register master
// that never issues read and write strobes in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module crc_engine #(
  parameter int MEM_DEPTH = 16,
  parameter int PTR_W = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Register port
  input wire crc_ctrl_pkg::bus_req_s req_i,
  output logic [crc_ctrl_pkg::DATA_W-1:0] rdata_o,
  // Chip power state
  input wire logic chip_idle_i,
  // Interrupt
  output logic irq_o
);

  localparam int DW = crc_ctrl_pkg::DATA_W;
  localparam int FW = crc_ctrl_pkg::FIELD_W;
  localparam int CW = crc_ctrl_pkg::CNT_W;

  initial begin
    // Pointers wrap at a power of two, so the store must be exactly that deep
    if (MEM_DEPTH < 16 || MEM_DEPTH != (1 << PTR_W)) begin
      $error("crc_engine: MEM_DEPTH must hold 16 words and equal 2**PTR_W");
    end
  end

  // Control and engine state
  logic [crc_ctrl_pkg::CTRL_W-1:0] ctrl1_reg;
  logic [crc_ctrl_pkg::CTRL_W-1:0] ctrl2_reg;
  logic [DW-1:0] poly_reg;
  logic [DW-1:0] crc_reg;
  logic [DW-1:0] crc_next;
  logic [DW-1:0] shreg_reg;
  logic [DW-1:0] shreg_next;
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic [FW-1:0] bit_cnt_reg;
  logic [FW-1:0] bit_cnt_next;
  logic [crc_ctrl_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [crc_ctrl_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [crc_ctrl_pkg::IRQ_W-1:0] irq_event;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;
  crc_ctrl_pkg::eng_state_e state_reg;
  crc_ctrl_pkg::eng_state_e state_next;

  // Decoded control fields
  wire unit_enable = ctrl1_reg[crc_ctrl_pkg::BIT_UNIT_EN];
  wire idle_stop = ctrl1_reg[crc_ctrl_pkg::BIT_IDLE_STOP];
  wire irq_source_select = ctrl1_reg[crc_ctrl_pkg::BIT_ISEL];
  wire shift_go = ctrl1_reg[crc_ctrl_pkg::BIT_GO];
  wire lsb_first_order = ctrl1_reg[crc_ctrl_pkg::BIT_LSB_FIRST];
  wire [FW-1:0] data_width_field = ctrl2_reg[crc_ctrl_pkg::DW_LSB +: FW];
  wire [FW-1:0] poly_length_field = ctrl2_reg[crc_ctrl_pkg::PL_LSB +: FW];

  // Register port decode
  wire wr_ctrl1 = req_i.wr && req_i.addr == crc_ctrl_pkg::OFF_CTRL1;
  wire wr_ctrl2 = req_i.wr && req_i.addr == crc_ctrl_pkg::OFF_CTRL2;
  wire wr_data = req_i.wr && req_i.addr == crc_ctrl_pkg::OFF_DATA;
  wire wr_result = req_i.wr && req_i.addr == crc_ctrl_pkg::OFF_RESULT;
  wire wr_poly = req_i.wr && req_i.addr == crc_ctrl_pkg::OFF_POLY;
  wire wr_mask = req_i.wr && req_i.addr == crc_ctrl_pkg::OFF_IRQ_MASK;
  wire rd_stat = req_i.rd && req_i.addr == crc_ctrl_pkg::OFF_IRQ_STAT;

  wire [CW-1:0] fifo_depth = (poly_length_field <= crc_ctrl_pkg::PLEN_SHORT_MAX) ?
                             crc_ctrl_pkg::DEPTH_SHORT_POLY : crc_ctrl_pkg::DEPTH_LONG_POLY;
  wire fifo_full_flag = count_reg >= fifo_depth;
  wire fifo_empty_flag = count_reg == 5'h00;

  // Idle halts the engine only when idle stop is set
  wire halted = idle_stop && chip_idle_i;
  // Shift go gates every engine step
  wire run = unit_enable && shift_go && !halted;

  // Pushes need the unit on; a push into a full FIFO is dropped and flagged
  wire push = wr_data && unit_enable && !fifo_full_flag;
  wire push_drop = wr_data && unit_enable && fifo_full_flag;
  // Pop from idle or on the last shift cycle so words run back to back; never
  // in the fetch cycle, whose word is still on its way out of the memory
  wire last_shift = state_reg == crc_ctrl_pkg::ST_SHIFT && bit_cnt_reg == 5'h00;
  wire pop = run && !fifo_empty_flag && (state_reg == crc_ctrl_pkg::ST_IDLE || last_shift);
  wire [DW-1:0] mem_rdata;

  // Polynomial length mask, field plus one bits
  wire [DW-1:0] len_mask = {DW{1'b1}} >> (5'h1f - poly_length_field);
  wire [DW-1:0] top_sel = {{(DW-1){1'b0}}, 1'b1} << poly_length_field;

  // Next input bit, taken from either end of the shift register
  wire in_bit = lsb_first_order ? shreg_reg[0] : shreg_reg[DW-1];
  wire fb_bit = in_bit ^ |(crc_reg & top_sel);

  // MSB-first words aligned so the top data bit sits at the MSB end; LSB-first words load unshifted
  wire [DW-1:0] word_aligned = lsb_first_order ? mem_rdata :
                               mem_rdata << (5'h1f - data_width_field);

  // FIFO storage
  crc_word_mem #(
    .WIDTH(DW),
    .DEPTH(MEM_DEPTH),
    .AW(PTR_W)
  ) u_mem (
    .clock_i(clock_i),
    .wr_en_i(push),
    .wr_addr_i(wr_ptr_reg),
    .wr_data_i(req_i.wdata),
    .rd_en_i(pop),
    .rd_addr_i(rd_ptr_reg),
    .rd_data_o(mem_rdata)
  );

  // Engine sequencing: a pop issues the read, the next cycle loads the word
  always_comb begin
    state_next = state_reg;
    shreg_next = shreg_reg;
    bit_cnt_next = bit_cnt_reg;
    crc_next = crc_reg;
    irq_event = '0;
    irq_event[crc_ctrl_pkg::IRQ_DROP] = push_drop;
    // Event on the pop that empties the FIFO
    if (irq_source_select && pop && count_reg == 5'h01 && !push) begin
      irq_event[crc_ctrl_pkg::IRQ_CRC] = 1'b1;
    end
    if (run) begin
      case (state_reg)
        crc_ctrl_pkg::ST_IDLE: begin
          if (pop) begin
            state_next = crc_ctrl_pkg::ST_FETCH;
          end
        end
        crc_ctrl_pkg::ST_FETCH: begin
          shreg_next = word_aligned;
          bit_cnt_next = data_width_field;
          state_next = crc_ctrl_pkg::ST_SHIFT;
        end
        crc_ctrl_pkg::ST_SHIFT: begin
          crc_next = ((crc_reg << 1) ^ (fb_bit ? poly_reg : '0)) & len_mask;
          shreg_next = lsb_first_order ? shreg_reg >> 1 : shreg_reg << 1;
          if (bit_cnt_reg == 5'h00) begin
            if (pop) begin
              state_next = crc_ctrl_pkg::ST_FETCH;
            end else begin
              state_next = crc_ctrl_pkg::ST_IDLE;
              // Event once the last bit is in and the result is valid
              if (!irq_source_select && fifo_empty_flag) begin
                irq_event[crc_ctrl_pkg::IRQ_CRC] = 1'b1;
              end
            end
          end else begin
            bit_cnt_next = bit_cnt_reg - 5'h01;
          end
        end
        default: begin
          state_next = crc_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Word count follows a push and a pop in the same cycle
  assign count_next = count_reg + {4'h0, push} - {4'h0, pop};

  // Control registers; only the documented bits are writable
  // Unimplemented bits masked on write
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl1_reg <= crc_ctrl_pkg::CTRL1_RESET;
      ctrl2_reg <= crc_ctrl_pkg::CTRL2_RESET;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_reg <= req_i.wdata[crc_ctrl_pkg::CTRL_W-1:0] & crc_ctrl_pkg::CTRL1_WMASK;
      end
      if (wr_ctrl2) begin
        ctrl2_reg <= req_i.wdata[crc_ctrl_pkg::CTRL_W-1:0] & crc_ctrl_pkg::CTRL2_WMASK;
      end
    end
  end

  // Polynomial and interrupt mask; a disable leaves both alone
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      poly_reg <= crc_ctrl_pkg::POLY_RESET;
      irq_mask_reg <= crc_ctrl_pkg::IRQ_RESET;
    end else begin
      if (wr_poly) begin
        poly_reg <= req_i.wdata;
      end
      if (wr_mask) begin
        irq_mask_reg <= req_i.wdata[crc_ctrl_pkg::IRQ_W-1:0];
      end
    end
  end

  // Disable is local reset; a disabled unit holds the engine in reset but keeps the controls
  wire engine_clear = srst_i || !unit_enable;

  // Engine state and bit counter
  always_ff @(posedge clock_i) begin
    if (engine_clear) begin
      state_reg <= crc_ctrl_pkg::ST_IDLE;
      bit_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // FIFO pointers and word count; the count tells full from empty as pointers wrap
  always_ff @(posedge clock_i) begin
    if (engine_clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PTR_W'(push);
      rd_ptr_reg <= rd_ptr_reg + PTR_W'(pop);
      count_reg <= count_next;
    end
  end

  // Data holding register
  always_ff @(posedge clock_i) begin
    if (engine_clear) begin
      shreg_reg <= '0;
    end else begin
      shreg_reg <= shreg_next;
    end
  end

  // Result register; a write preloads the seed, cut to the polynomial length
  always_ff @(posedge clock_i) begin
    if (engine_clear) begin
      crc_reg <= crc_ctrl_pkg::SEED_RESET;
    end else begin
      crc_reg <= wr_result ? req_i.wdata & len_mask : crc_next;
    end
  end

  // Sticky status; a new event wins over the clear by read
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_stat_reg <= crc_ctrl_pkg::IRQ_RESET;
    end else begin
      irq_stat_reg <= (rd_stat ? '0 : irq_stat_reg) | irq_event;
    end
  end

  // Read mux; unmapped addresses read zero
  // Count and flags shown in the primary control word
  always_comb begin
    rdata_next = '0;
    case (req_i.addr)
      crc_ctrl_pkg::OFF_CTRL1: begin
        rdata_next[crc_ctrl_pkg::CTRL_W-1:0] = ctrl1_reg;
        rdata_next[crc_ctrl_pkg::CNT_LSB +: CW] = count_reg;
        rdata_next[crc_ctrl_pkg::BIT_FULL] = fifo_full_flag;
        rdata_next[crc_ctrl_pkg::BIT_EMPTY] = fifo_empty_flag;
      end
      crc_ctrl_pkg::OFF_CTRL2: begin
        rdata_next[crc_ctrl_pkg::CTRL_W-1:0] = ctrl2_reg;
      end
      crc_ctrl_pkg::OFF_RESULT: begin
        rdata_next = crc_reg & len_mask;
      end
      crc_ctrl_pkg::OFF_POLY: begin
        rdata_next = poly_reg;
      end
      crc_ctrl_pkg::OFF_IRQ_STAT: begin
        rdata_next[crc_ctrl_pkg::IRQ_W-1:0] = irq_stat_reg;
      end
      crc_ctrl_pkg::OFF_IRQ_MASK: begin
        rdata_next[crc_ctrl_pkg::IRQ_W-1:0] = irq_mask_reg;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= req_i.rd ? rdata_next : '0;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

endmodule
`default_nettype wire

// >>> crc_engine_props.sv
// Checker for the CRC engine register port and interrupt.
// Assumes it is bound to crc_engine and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module crc_engine_props #(
  parameter int MEM_DEPTH = 16,
  parameter int PTR_W = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Observed ports
  input wire crc_ctrl_pkg::bus_req_s req_i,
  input wire logic [crc_ctrl_pkg::DATA_W-1:0] rdata_o,
  input wire logic chip_idle_i,
  input wire logic irq_o
);
  logic [15:0] ctrl1_reg;
  logic [15:0] ctrl2_reg;
  logic [1:0] mask_reg;
  // Read decodes and the FIFO depth implied by the last polynomial length
  wire logic rd0 = req_i.rd && (req_i.addr == crc_ctrl_pkg::OFF_CTRL1);
  wire logic rd1 = req_i.rd && (req_i.addr == crc_ctrl_pkg::OFF_CTRL2);
  wire logic rd2 = req_i.rd && (req_i.addr == crc_ctrl_pkg::OFF_DATA);
  wire logic [4:0] cnt = rdata_o[12:8];
  wire logic short_pl = ctrl2_reg[4:0] <= crc_ctrl_pkg::PLEN_SHORT_MAX;
  wire logic [4:0] depth = short_pl ? 5'h10 : 5'h08;
  // Shadows rebuilt from observed writes, since the checker cannot see inside
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl1_reg <= 16'h0000;
      ctrl2_reg <= 16'h0000;
      mask_reg <= 2'h0;
    end else if (req_i.wr) begin
      if (req_i.addr == crc_ctrl_pkg::OFF_CTRL1) ctrl1_reg <= req_i.wdata[15:0] & 16'ha038;
      if (req_i.addr == crc_ctrl_pkg::OFF_CTRL2) ctrl2_reg <= req_i.wdata[15:0] & 16'h1f1f;
      if (req_i.addr == crc_ctrl_pkg::OFF_IRQ_MASK) mask_reg <= req_i.wdata[1:0];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  rdata_quiet_a: assert property (!req_i.rd |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  ctrl1_rsvd_a: assert property (rd0 |=> rdata_o[31:16] == 16'h0 && !rdata_o[14] && rdata_o[2:0] == 3'h0)
    else $error("reserved primary control bits not zero");
  ctrl1_back_a: assert property (rd0 |=> (rdata_o[15:0] & 16'ha038) == ctrl1_reg)
    else $error("primary control readback wrong");
  ctrl2_back_a: assert property (rd1 |=> rdata_o == {16'h0, ctrl2_reg})
    else $error("width control readback wrong");
  data_read_a: assert property (rd2 |=> rdata_o == 32'h0)
    else $error("data input read not zero");
  empty_flag_a: assert property (rd0 |=> rdata_o[6] == (cnt == 5'h0) && cnt <= 5'h10)
    else $error("empty flag or count out of range");
  full_flag_a: assert property (rd0 |=> rdata_o[7] == (cnt >= depth))
    else $error("full flag disagrees with depth");
  disabled_clear_a: assert property (rd0 && !ctrl1_reg[15] && $past(!ctrl1_reg[15]) |=> cnt == 5'h0 && rdata_o[6])
    else $error("disabled engine holds FIFO words");
  irq_masked_a: assert property (irq_o |-> mask_reg != 2'h0)
    else $error("interrupt with all sources masked");
endmodule
bind crc_engine crc_engine_props #(.MEM_DEPTH(MEM_DEPTH), .PTR_W(PTR_W)) props_i (
  .clock_i(clock_i), .srst_i(srst_i), .req_i(req_i), .rdata_o(rdata_o),
  .chip_idle_i(chip_idle_i), .irq_o(irq_o));
`default_nettype wire

// >>> programmable_crc_engine_control_tb.sv
// Self-checking bench for the CRC engine: register access, FIFO, idle stop, results.
// Assumes the plain strobe port with read data in the cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
module programmable_crc_engine_control_tb;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic chip_idle_i = 1'b0;
  crc_ctrl_pkg::bus_req_s req = '0;
  logic [31:0] rdata_o;
  logic irq_o;
  int err_count = 0;
  int checks_done = 0;
  int n;
  logic [31:0] pair_exp;
  crc_engine dut (.clock_i(clock_i), .srst_i(srst_i), .req_i(req), .rdata_o(rdata_o),
    .chip_idle_i(chip_idle_i), .irq_o(irq_o));
  // Free-running 250 MHz clock
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobes last one cycle; the next access starts a cycle later
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clock_i);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    rd(a, v);
    check(nm, v, e);
  endtask
  // Bounded wait; running out ends the run as a failure
  task automatic wait_irq(output int k);
    k = 0;
    while (irq_o !== 1'b1) begin
      @(posedge clock_i);
      #1;
      k++;
      if (k > 200) begin
        err_count++;
        complete_run();
      end
    end
  endtask
  // Reference shift: feedback from the top result bit at the polynomial length, result masked to length
  function automatic logic [31:0] crc_ref(input logic [31:0] seed, input logic [31:0] w,
      input logic [31:0] poly, input int dw, input int pl, input logic lsb);
    logic [31:0] m;
    logic [31:0] c;
    logic fb;
    m = (pl == 31) ? 32'hffffffff : ((32'h1 << (pl + 1)) - 32'h1);
    c = seed & m;
    for (int i = 0; i <= dw; i++) begin
      fb = (lsb ? w[i] : w[dw - i]) ^ c[pl];
      c = ((c << 1) ^ (fb ? poly : 32'h0)) & m;
    end
    return c;
  endfunction
  task automatic run_case(input int dw, input int pl, input logic lsb, input logic isel,
      input logic [31:0] poly, input logic [31:0] seed, input logic [31:0] w);
    logic [31:0] v;
    logic [15:0] c1;
    int k;
    c1 = 16'h8000 | (16'(isel) << 5) | (16'(lsb) << 3);
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'h0);
    wr(crc_ctrl_pkg::OFF_CTRL2, 32'((dw << 8) | pl));
    wr(crc_ctrl_pkg::OFF_POLY, poly);
    wr(crc_ctrl_pkg::OFF_IRQ_MASK, 32'h1);
    wr(crc_ctrl_pkg::OFF_CTRL1, {16'h0, c1});
    wr(crc_ctrl_pkg::OFF_RESULT, seed);
    rd(crc_ctrl_pkg::OFF_IRQ_STAT, v);
    wr(crc_ctrl_pkg::OFF_CTRL1, {16'h0, c1 | 16'h0010});
    wr(crc_ctrl_pkg::OFF_DATA, w);
    wait_irq(k);
    if (isel) check("irq on empty", 32'(k < 5), 32'h1);
    else check("irq on done", 32'(k > dw), 32'h1);
    repeat (40) @(posedge clock_i);
    rdc(crc_ctrl_pkg::OFF_RESULT, crc_ref(seed, w, poly, dw, pl, lsb), "result");
    rdc(crc_ctrl_pkg::OFF_IRQ_STAT, 32'h1, "crc event");
    check("irq cleared", {31'h0, irq_o}, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    rdc(crc_ctrl_pkg::OFF_CTRL1, 32'h0040, "ctrl1 reset");
    rdc(crc_ctrl_pkg::OFF_CTRL2, 32'h0, "ctrl2 reset");
    rdc(3'h7, 32'h0, "unmapped");
    wr(crc_ctrl_pkg::OFF_CTRL2, 32'hffffffff);
    rdc(crc_ctrl_pkg::OFF_CTRL2, 32'h1f1f, "ctrl2 bits");
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'hffffffff);
    rdc(crc_ctrl_pkg::OFF_CTRL1, 32'ha078, "ctrl1 bits");
    // Shifter off: FIFO fills to 16 with a short polynomial, then refuses
    wr(crc_ctrl_pkg::OFF_CTRL2, 32'h0007);
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'h8000);
    for (int i = 0; i < 17; i++) wr(crc_ctrl_pkg::OFF_DATA, 32'(i));
    rdc(crc_ctrl_pkg::OFF_CTRL1, 32'h9080, "full at 16");
    check("irq masked", {31'h0, irq_o}, 32'h0);
    rdc(crc_ctrl_pkg::OFF_IRQ_STAT, 32'h2, "dropped push");
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'h0);
    rdc(crc_ctrl_pkg::OFF_CTRL1, 32'h0040, "disable clears");
    rdc(crc_ctrl_pkg::OFF_CTRL2, 32'h0007, "controls kept");
    wr(crc_ctrl_pkg::OFF_CTRL2, 32'h0008);
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'h8000);
    for (int i = 0; i < 8; i++) wr(crc_ctrl_pkg::OFF_DATA, 32'(i));
    rdc(crc_ctrl_pkg::OFF_CTRL1, 32'h8880, "full at 8");
    // Idle stop freezes the shifter until the chip leaves idle
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'h0);
    wr(crc_ctrl_pkg::OFF_IRQ_MASK, 32'h1);
    wr(crc_ctrl_pkg::OFF_CTRL2, 32'h0707);
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'ha000);
    rdc(crc_ctrl_pkg::OFF_IRQ_STAT, 32'h0, "status quiet");
    @(posedge clock_i);
    chip_idle_i <= 1'b1;
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'ha010);
    wr(crc_ctrl_pkg::OFF_DATA, 32'h5);
    repeat (30) @(posedge clock_i);
    rdc(crc_ctrl_pkg::OFF_CTRL1, 32'ha110, "idle halt");
    @(posedge clock_i);
    chip_idle_i <= 1'b0;
    wait_irq(n);
    rdc(crc_ctrl_pkg::OFF_IRQ_STAT, 32'h1, "resumed");
    // Idle stop off: cases run with the chip idle
    @(posedge clock_i);
    chip_idle_i <= 1'b1;
    run_case(7, 7, 1'b0, 1'b0, 32'h00000007, 32'h0, 32'hffffff5a);
    run_case(15, 15, 1'b1, 1'b1, 32'h00001021, 32'h0000ffff, 32'h12343c4d);
    run_case(31, 31, 1'b1, 1'b0, 32'h04c11db7, 32'hffffffff, 32'hdeadbeef);
    run_case(5, 4, 1'b0, 1'b1, 32'h00000015, 32'h0, 32'hffffffe9);
    // Two words queued with the shifter off, then shifted back to back
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'h8020);
    wr(crc_ctrl_pkg::OFF_DATA, 32'h0000002a);
    wr(crc_ctrl_pkg::OFF_DATA, 32'h00000013);
    rdc(crc_ctrl_pkg::OFF_CTRL1, 32'h8220, "two queued");
    wr(crc_ctrl_pkg::OFF_CTRL1, 32'h8030);
    repeat (40) @(posedge clock_i);
    pair_exp = crc_ref(32'h0, 32'hffffffe9, 32'h15, 5, 4, 1'b0);
    pair_exp = crc_ref(pair_exp, 32'h2a, 32'h15, 5, 4, 1'b0);
    pair_exp = crc_ref(pair_exp, 32'h13, 32'h15, 5, 4, 1'b0);
    rdc(crc_ctrl_pkg::OFF_RESULT, pair_exp, "two words");
    rdc(crc_ctrl_pkg::OFF_IRQ_STAT, 32'h1, "empty event");
    rdc(crc_ctrl_pkg::OFF_CTRL1, 32'h8070, "drained");
    complete_run();
  end
endmodule
`default_nettype wire
